/* rtl/engine_if.sv */
// Interface: control and status between register bank and engine
`timescale 1ns/1ns
`default_nettype none
interface engine_if;
    import field_rules_pkg::*;

    logic                 start;
    logic                 clear;
    logic                 enable;
    logic                 valid_enable;
    logic [RUN_LEN_W-1:0] run_len;
    logic                 busy;
    logic                 done;
    logic                 result_valid;
    logic [COUNT_W-1:0]   count;

    modport regs (
        output start,
        output clear,
        output enable,
        output valid_enable,
        output run_len,
        input  busy,
        input  done,
        input  result_valid,
        input  count
    );

    modport engine (
        input  start,
        input  clear,
        input  enable,
        input  valid_enable,
        input  run_len,
        output busy,
        output done,
        output result_valid,
        output count
    );
endinterface : engine_if
`default_nettype wire

/* rtl/field_engine.sv */
// Timed operation engine whose progress and result the bank reports
`timescale 1ns/1ns
`default_nettype none
module field_engine (
    input  wire logic clk_i,
    input  wire logic rst_i,
    engine_if.engine  ctl
);
    import field_rules_pkg::*;

    localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYCLES - 1);

    engine_state_e        state_reg;
    engine_state_e        state_next;
    logic [STEP_CNT_W-1:0] step_reg;
    logic [RUN_LEN_W-1:0]  len_reg;
    logic                  valid_reg;
    logic [COUNT_W-1:0]    count_reg;

    // ************************************************************
    // State machine
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (ctl.start) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (step_reg == STEP_LAST && len_reg <= 8'h01) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
        endcase
        // Dropping the enable aborts from any state
        if (!ctl.enable) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // Step and length counters
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_reg <= '0;
            len_reg  <= '0;
        end else if (state_reg == ST_IDLE) begin
            step_reg <= '0;
            len_reg  <= ctl.run_len;
        end else if (step_reg == STEP_LAST) begin
            step_reg <= '0;
            len_reg  <= len_reg - 8'h01;
        end else begin
            step_reg <= step_reg + 4'h1;
        end
    end

    // ************************************************************
    // Result tracking; completion wins over a clear
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_reg <= 1'b0;
        end else if (state_reg == ST_DONE && ctl.valid_enable) begin
            valid_reg <= 1'b1;
        end else if (ctl.clear || ctl.start || !ctl.valid_enable) begin
            valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= COUNT_RESET;
        end else if (state_reg == ST_DONE) begin
            count_reg <= ctl.clear ? 16'h0001 : count_reg + 16'h0001;
        end else if (ctl.clear) begin
            count_reg <= COUNT_RESET;
        end
    end

    assign ctl.busy         = (state_reg != ST_IDLE);
    assign ctl.done         = (state_reg == ST_DONE);
    assign ctl.result_valid = valid_reg;
    assign ctl.count        = count_reg;
endmodule // field_engine
`default_nettype wire

/* rtl/field_rules_bank.sv */
// APB register bank that applies reserved, RO, WO and label field rules
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module field_rules_bank #(
    parameter bit                 ENGINE_PRESENT = 1'b1,
    parameter bit                 VALID_PRESENT  = 1'b1,
    // Arbitrary identification value
    parameter logic [31:0]        IDENT_VALUE    = 32'h0000_0A5A
) (
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    input  wire logic                                   psel_i,
    input  wire logic                                   penable_i,
    input  wire logic                                   pwrite_i,
    input  wire logic [field_rules_pkg::APB_ADDR_W-1:0] paddr_i,
    input  wire logic [field_rules_pkg::APB_DATA_W-1:0] pwdata_i,
    input  wire logic [field_rules_pkg::APB_STRB_W-1:0] pstrb_i,
    output var  logic [field_rules_pkg::APB_DATA_W-1:0] prdata_o,
    output var  logic                                   pready_o,
    output var  logic                                   pslverr_o
);
    import field_rules_pkg::*;

    // ************************************************************
    // Feature-dependent masks
    // ************************************************************
    // Absent features turn their control bits into plain reserved bits
    localparam logic [APB_DATA_W-1:0] CTL_WMASK =
        (ENGINE_PRESENT ? CTL_ENGINE_MASK : 32'h0000_0000) |
        (VALID_PRESENT  ? CTL_VALID_MASK  : 32'h0000_0000);
    localparam logic [APB_DATA_W-1:0] CTL_RESET_EFF = CONTROL_RESET & CTL_WMASK;

    // ************************************************************
    // Declarations
    // ************************************************************
    engine_if                  eng ();
    logic [APB_DATA_W-1:0]     lane_mask;
    logic [APB_ADDR_W-1:0]     word_addr;
    logic                      hit_cap;
    logic                      hit_ctl;
    logic                      hit_sts;
    logic                      hit_cmd;
    logic                      hit_evt;
    logic                      hit_scr;
    logic                      hit_id;
    logic                      hit_any;
    logic                      access_end;
    logic                      wr_end;
    logic                      answer_now;
    logic [APB_DATA_W-1:0]     rdata_next;
    logic [APB_DATA_W-1:0]     control_reg;
    logic [APB_DATA_W-1:0]     scratch_reg;
    logic                      done_event_reg;
    logic                      start_reg;
    logic                      clear_reg;
    logic [APB_DATA_W-1:0]     prdata_reg;
    logic                      pready_reg;
    logic                      pslverr_reg;
    logic [APB_DATA_W-1:0]     cap_word;
    logic [APB_DATA_W-1:0]     sts_word;

    // ************************************************************
    // Byte lanes
    // ************************************************************
    // Lane b carries bits 8b+7..8b: least significant byte on lane 0
    for (genvar b = 0; b < APB_STRB_W; b++) begin : g_lane
        assign lane_mask[b*8 +: 8] = {8{pstrb_i[b]}};
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    // Low two address bits are ignored; every register is one word
    assign word_addr  = {paddr_i[APB_ADDR_W-1:2], 2'b00};
    assign hit_cap    = (word_addr == CAPABILITY_OFS);
    assign hit_ctl    = (word_addr == CONTROL_OFS);
    assign hit_sts    = (word_addr == STATUS_OFS);
    assign hit_cmd    = (word_addr == COMMAND_OFS);
    assign hit_evt    = (word_addr == EVENT_OFS);
    assign hit_scr    = (word_addr == SCRATCH_OFS);
    assign hit_id     = (word_addr == IDENT_OFS);
    assign hit_any    = hit_cap | hit_ctl | hit_sts | hit_cmd |
                        hit_evt | hit_scr | hit_id;

    // The answer is raised one cycle into the access phase, the transfer
    // ends on the edge that sees it; one wait state keeps outputs registered
    assign answer_now = psel_i & penable_i & ~pready_reg;
    assign access_end = psel_i & penable_i & pready_reg;
    assign wr_end     = access_end & pwrite_i;

    // ************************************************************
    // Control register
    // ************************************************************
    // Only implemented bits are stored, so reserved and preserve-type
    // positions can never hold a value that leaks back on a read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_reg <= CTL_RESET_EFF;
        end else if (wr_end && hit_ctl) begin
            control_reg <= (control_reg & ~(CTL_WMASK & lane_mask)) |
                           (pwdata_i & CTL_WMASK & lane_mask);
        end
    end

    // ************************************************************
    // Scratch register
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scratch_reg <= SCRATCH_RESET;
        end else if (wr_end && hit_scr) begin
            scratch_reg <= (scratch_reg & ~lane_mask) |
                           (pwdata_i & lane_mask);
        end
    end

    // ************************************************************
    // Command strobes
    // ************************************************************
    // Upper command bits are a reserved field and are ignored on receipt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_reg <= 1'b0;
            clear_reg <= 1'b0;
        end else begin
            start_reg <= wr_end & hit_cmd & pstrb_i[0] &
                         pwdata_i[CMD_START_BIT] &
                         control_reg[CTL_ENGINE_ENABLE_BIT];
            clear_reg <= wr_end & hit_cmd & pstrb_i[0] &
                         pwdata_i[CMD_CLEAR_BIT];
        end
    end

    // ************************************************************
    // Completion event, write one to clear
    // ************************************************************
    // A completion that lands with the clearing write keeps the bit set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_event_reg <= 1'b0;
        end else if (eng.done) begin
            done_event_reg <= 1'b1;
        end else if (wr_end && hit_evt && pstrb_i[0] &&
                     pwdata_i[EVT_DONE_BIT]) begin
            done_event_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Engine hookup
    // ************************************************************
    assign eng.start        = start_reg;
    assign eng.clear        = clear_reg;
    assign eng.enable       = control_reg[CTL_ENGINE_ENABLE_BIT];
    assign eng.valid_enable = control_reg[CTL_VALID_ENABLE_BIT];
    assign eng.run_len      = control_reg[CTL_RUN_LEN_LSB +: RUN_LEN_W];

    field_engine u_engine (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ctl   (eng.engine)
    );

    // ************************************************************
    // Read words
    // ************************************************************
    always_comb begin
        cap_word = '0;
        cap_word[CAP_ENGINE_SUPPORT_BIT] = ENGINE_PRESENT;
        cap_word[CAP_VALID_SUPPORT_BIT]  = VALID_PRESENT;
    end

    always_comb begin
        sts_word = '0;
        sts_word[STS_IN_PROGRESS_BIT] = eng.busy;
        // Valid is forced to zero when its feature is absent
        sts_word[STS_RESULT_VALID_BIT] = VALID_PRESENT &
                                         eng.result_valid;
        sts_word[STS_COUNT_LSB +: COUNT_W] =
            ENGINE_PRESENT ? eng.count : 16'h0000;
    end

    always_comb begin
        rdata_next = '0;
        unique case (1'b1)
            hit_cap: rdata_next = cap_word;
            hit_ctl: rdata_next = control_reg & CTL_WMASK &
                                  ~CTL_PRESERVE_MASK;
            hit_sts: rdata_next = sts_word;
            hit_cmd: rdata_next = '0;
            hit_evt: rdata_next = {31'h0000_0000, done_event_reg} &
                                  ~EVT_ZERO_MASK;
            hit_scr: rdata_next = scratch_reg;
            hit_id:  rdata_next = IDENT_VALUE;
            default: rdata_next = '0;
        endcase
    end

    // ************************************************************
    // Answer registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= answer_now;
        end
    end

    // Read data is zero outside a read answer, so idle cycles drive no stale
    // value and every reserved bit goes out as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_reg <= '0;
        end else if (answer_now && !pwrite_i) begin
            prdata_reg <= rdata_next;
        end else begin
            prdata_reg <= '0;
        end
    end

    // Only unmapped words signal an error; writes to read-only words and
    // reads of the write-only word finish cleanly
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= answer_now & ~hit_any;
        end
    end

    assign prdata_o  = prdata_reg;
    assign pready_o  = pready_reg;
    assign pslverr_o = pslverr_reg;
endmodule // field_rules_bank
`default_nettype wire

/* rtl/field_rules_pkg.sv */
// Package: register map, field layouts, reset values and engine states
package field_rules_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int unsigned APB_ADDR_W = 12;
    localparam int unsigned APB_DATA_W = 32;
    localparam int unsigned APB_STRB_W = APB_DATA_W / 8;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [APB_ADDR_W-1:0] CAPABILITY_OFS = 12'h000;
    localparam logic [APB_ADDR_W-1:0] CONTROL_OFS    = 12'h004;
    localparam logic [APB_ADDR_W-1:0] STATUS_OFS     = 12'h008;
    localparam logic [APB_ADDR_W-1:0] COMMAND_OFS    = 12'h00C;
    localparam logic [APB_ADDR_W-1:0] EVENT_OFS      = 12'h010;
    localparam logic [APB_ADDR_W-1:0] SCRATCH_OFS    = 12'h014;
    localparam logic [APB_ADDR_W-1:0] IDENT_OFS      = 12'h018;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned CAP_ENGINE_SUPPORT_BIT = 0;
    localparam int unsigned CAP_VALID_SUPPORT_BIT  = 1;
    localparam int unsigned CTL_ENGINE_ENABLE_BIT  = 0;
    localparam int unsigned CTL_VALID_ENABLE_BIT   = 1;
    localparam int unsigned CTL_RUN_LEN_LSB        = 8;
    localparam int unsigned RUN_LEN_W              = 8;
    localparam int unsigned STS_IN_PROGRESS_BIT    = 0;
    localparam int unsigned STS_RESULT_VALID_BIT   = 1;
    localparam int unsigned STS_COUNT_LSB          = 16;
    localparam int unsigned COUNT_W                = 16;
    localparam int unsigned CMD_START_BIT          = 0;
    localparam int unsigned CMD_CLEAR_BIT          = 1;
    localparam int unsigned EVT_DONE_BIT           = 0;

    // Writable bits of the control word when every feature is present
    localparam logic [APB_DATA_W-1:0] CTL_ENGINE_MASK = 32'h0000_FF01;
    localparam logic [APB_DATA_W-1:0] CTL_VALID_MASK  = 32'h0000_0002;
    // Preserve-type reserved span of the control word
    localparam logic [APB_DATA_W-1:0] CTL_PRESERVE_MASK = 32'h00FF_0000;
    // Zero-type reserved span of the event word
    localparam logic [APB_DATA_W-1:0] EVT_ZERO_MASK = 32'h0000_00FE;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [APB_DATA_W-1:0] CONTROL_RESET = 32'h0000_0100;
    localparam logic [APB_DATA_W-1:0] SCRATCH_RESET = 32'h0000_0000;
    localparam logic [COUNT_W-1:0]    COUNT_RESET   = 16'h0000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_KHZ      = 25000;
    localparam int unsigned STEP_TIME_NS = 400;
    // Least time: round up to whole cycles
    localparam int unsigned STEP_CYCLES  =
        (STEP_TIME_NS * CLK_KHZ + 999999) / 1000000;
    localparam int unsigned STEP_CNT_W   = 4;

    // ************************************************************
    // Engine states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_DONE = 3'b100
    } engine_state_e;

endpackage : field_rules_pkg

/* verification/field_rules_monitor.sv */
// Port checker for the field rules register bank
`timescale 1ns/1ns
`default_nettype none
module field_rules_monitor #(
    parameter bit          ENGINE_PRESENT = 1'b1,
    parameter bit          VALID_PRESENT  = 1'b1,
    parameter logic [31:0] IDENT_VALUE    = 32'h0000_0A5A
) (
    input wire logic                                   clk_i,
    input wire logic                                   rst_i,
    input wire logic                                   psel_i,
    input wire logic                                   penable_i,
    input wire logic                                   pwrite_i,
    input wire logic [field_rules_pkg::APB_ADDR_W-1:0] paddr_i,
    input wire logic [field_rules_pkg::APB_DATA_W-1:0] pwdata_i,
    input wire logic [field_rules_pkg::APB_STRB_W-1:0] pstrb_i,
    input wire logic [field_rules_pkg::APB_DATA_W-1:0] prdata_o,
    input wire logic                                   pready_o,
    input wire logic                                   pslverr_o
);
    import field_rules_pkg::*;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ************************************************************
    // Access steps
    // ************************************************************
    sequence s_wait;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_read(int w);
        s_wait ##0 (!pwrite_i && paddr_i[11:2] == w);
    endsequence

    // ************************************************************
    // Checks
    // ************************************************************
    a_one_wait_state: assert property (
        $rose(penable_i) && psel_i |=> pready_o)
        else $error("ready not one cycle after enable");
    a_ready_pulse: assert property (
        pready_o |=> !pready_o)
        else $error("ready stands longer than one cycle");
    a_idle_quiet: assert property (
        !psel_i |=> !pready_o && !pslverr_o && prdata_o == '0)
        else $error("answer without a transfer");
    a_unmapped_err: assert property (
        s_wait ##0 paddr_i[11:2] > 10'd6 |=> pslverr_o && prdata_o == '0)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (
        s_wait ##0 paddr_i[11:2] <= 10'd6 |=> !pslverr_o)
        else $error("mapped access flagged");
    a_support_tied: assert property (
        s_read(0) |=>
        prdata_o == {30'h0, VALID_PRESENT, ENGINE_PRESENT})
        else $error("capability word wrong");
    a_ctl_reserved: assert property (
        s_read(1) |=>
        (prdata_o & ~(CTL_ENGINE_MASK | CTL_VALID_MASK)) == '0)
        else $error("control reserved bits nonzero");
    a_sts_reserved: assert property (
        s_read(2) |=> prdata_o[15:2] == '0)
        else $error("status reserved bits nonzero");
    a_cmd_reads_zero: assert property (
        s_read(3) |=> prdata_o == '0)
        else $error("command word not zero");
    a_evt_zero_field: assert property (
        s_read(4) |=> prdata_o[31:1] == '0)
        else $error("event reserved bits nonzero");
    a_ident_fixed: assert property (
        s_read(6) |=> prdata_o == IDENT_VALUE)
        else $error("ident word changed");
endmodule // field_rules_monitor
`default_nettype wire

/* verification/tb_top.sv */
// Testbench for the field rules register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("unexpected at %0t: %h not %h", $time, got, exp); \
        end \
    end
module tb_top;
    import field_rules_pkg::*;

    // Arbitrary identification value
    localparam logic [31:0] IDENT = 32'h0000_0C3C;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0]  pstrb_i = 4'h0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    int          mismatches = 0;
    int          n_compared = 0;
    logic [31:0] r;
    logic        e;
    logic        seen;

    field_rules_bank #(.IDENT_VALUE(IDENT)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

    always #20 clk_i = ~clk_i;

    // ************************************************************
    // Bus tasks
    // ************************************************************
    // Request held until the rising edge that samples pready high
    task automatic acc(input  logic        w,
                       input  logic [11:0] a,
                       input  logic [31:0] d,
                       input  logic [3:0]  s,
                       output logic [31:0] rd,
                       output logic        er);
        logic rdy;
        int   n;
        rdy = 1'b0;
        n = 0;
        rd = 32'h0;
        er = 1'b0;
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        pstrb_i  <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            rdy = pready_o;
            rd  = prdata_o;
            er  = pslverr_o;
            n++;
        end while (rdy !== 1'b1 && n < 20);
        `CHK(rdy, 1'b1)
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        logic [31:0] x;
        logic        y;
        acc(1'b1, a, d, s, x, y);
        `CHK(y, 1'b0)
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, 4'h0, r, e);
        `CHK(e, 1'b0)
        `CHK(r, exp)
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(CAPABILITY_OFS, 32'h0000_0003);
        rd_chk(CONTROL_OFS, CONTROL_RESET);
        rd_chk(STATUS_OFS, 32'h0);
        rd_chk(IDENT_OFS, IDENT);
        rd_chk(COMMAND_OFS, 32'h0);
        acc(1'b0, 12'h01C, 32'h0, 4'h0, r, e);
        `CHK({e, r}, 33'h1_0000_0000)
        $display("reset and map test done");
        wr(CAPABILITY_OFS, 32'hFFFF_FFFF);
        wr(STATUS_OFS, 32'hFFFF_FFFF);
        wr(IDENT_OFS, 32'hFFFF_FFFF);
        rd_chk(CAPABILITY_OFS, 32'h0000_0003);
        rd_chk(STATUS_OFS, 32'h0);
        rd_chk(IDENT_OFS, IDENT);
        wr(CONTROL_OFS, 32'hFFFF_FFFF);
        rd_chk(CONTROL_OFS, CTL_ENGINE_MASK | CTL_VALID_MASK);
        wr(SCRATCH_OFS, 32'h1122_3344);
        wr(SCRATCH_OFS, 32'hAABB_CCDD, 4'b0010);
        rd_chk(SCRATCH_OFS, 32'h1122_CC44);
        $display("write refusal test done");
        wr(CONTROL_OFS, 32'h0000_0103);
        rd_chk(CONTROL_OFS, 32'h0000_0103);
        wr(COMMAND_OFS, 32'h0000_0001);
        seen = 1'b0;
        for (int i = 0; i < 20; i++) begin
            acc(1'b0, STATUS_OFS, 32'h0, 4'h0, r, e);
            if (r[0] === 1'b1) seen = 1'b1;
            else if (seen) break;
        end
        `CHK(seen, 1'b1)
        rd_chk(STATUS_OFS, 32'h0001_0002);
        rd_chk(EVENT_OFS, 32'h0000_0001);
        wr(EVENT_OFS, 32'h0000_0001);
        rd_chk(EVENT_OFS, 32'h0);
        $display("engine run test done");
        wr(COMMAND_OFS, 32'h0000_0001);
        wr(CONTROL_OFS, 32'h0000_0100);
        rd_chk(STATUS_OFS, 32'h0001_0000);
        wr(COMMAND_OFS, 32'h0000_0001);
        rd_chk(STATUS_OFS, 32'h0001_0000);
        wr(COMMAND_OFS, 32'h0000_0002);
        rd_chk(STATUS_OFS, 32'h0);
        $display("abort and clear test done");
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end
endmodule // tb_top

bind field_rules_bank field_rules_monitor #(.ENGINE_PRESENT(ENGINE_PRESENT),
    .VALID_PRESENT(VALID_PRESENT), .IDENT_VALUE(IDENT_VALUE)) i_mon (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o));
`default_nettype wire
